// ### inc/cpg_pkg.sv
package cpg_pkg;
   //---------------------------------------------------------------
   // register access encoding (coprocessor 15 space)
   //---------------------------------------------------------------
   localparam logic [3:0]  CRN_PRIO       = 4'h0C;
   localparam logic [3:0]  CRM_G1_PRIO    = 4'h09;
   localparam logic [2:0]  OPC1_PRIO      = 3'h0;
   localparam logic [3:0]  OPC1_ALIAS     = 4'h1;
   localparam logic [3:0]  CRM_ALIAS      = 4'h0C;
   localparam int          NUM_PRIO_REGS  = 4;
   localparam logic [31:0] PRIO_RESET     = 32'h0000_0000;
   localparam int          PRIO_BITS_DEF  = 5;
   localparam int          PRIO_BITS_AP1  = 6;
   localparam int          PRIO_BITS_AP23 = 7;

   //---------------------------------------------------------------
   // alias register field layout
   //---------------------------------------------------------------
   localparam int AFF_LVL3_LSB   = 48;
   localparam int AFF_LVL2_LSB   = 32;
   localparam int AFF_LVL1_LSB   = 16;
   localparam int AFF_W          = 8;
   localparam int INTNUM_LSB     = 24;
   localparam int INTNUM_W       = 4;
   localparam int ROUTE_MODE_BIT = 40;
   localparam int TARGET_LSB     = 0;
   localparam int TARGET_W       = 16;

   //---------------------------------------------------------------
   // privilege levels and access outcome
   //---------------------------------------------------------------
   typedef enum logic [1:0] {
      CPG_EL0 = 2'h0,
      CPG_EL1 = 2'h1,
      CPG_EL2 = 2'h2,
      CPG_EL3 = 2'h3
   } cpg_level_e;

   typedef enum logic [2:0] {
      CPG_OK       = 3'h0,
      CPG_UNDEF    = 3'h1,
      CPG_TRAP_HYP = 3'h2,
      CPG_TRAP_MON = 3'h3,
      CPG_VIRTUAL  = 3'h4
   } cpg_result_e;

   typedef enum logic [1:0] {
      CPG_PKT_IDLE = 2'h0,
      CPG_PKT_SEND = 2'h1
   } cpg_pkt_e;
endpackage : cpg_pkg

// ### src/cpg_access_check.sv
`timescale 1ns/100ps
// classifies a system register access before it touches any state
module cpg_access_check (
   input  wire logic [1:0] level,
   input  wire logic       secureState,
   input  wire logic       isAlias,
   input  wire logic       isWrite,
   input  wire logic       sysregEnable,
   input  wire logic       irqRouteToHyp,
   input  wire logic       fiqRouteToHyp,
   input  wire logic       trapAllGroup1,
   input  wire logic       trapCommon,
   input  wire logic       hypTrapC12,
   input  wire logic       irqToMonitor,
   input  wire logic       fiqToMonitor,
   input  wire logic       monitorIs64,
   output logic      [2:0] result
);
   logic nsEl1;
   logic monTrap;

   always_comb begin
      nsEl1   = (level == cpg_pkg::CPG_EL1) && !secureState;
      monTrap = monitorIs64 && irqToMonitor && (!isAlias || fiqToMonitor);
      result  = cpg_pkg::CPG_OK;
      if (level == cpg_pkg::CPG_EL0) begin
         result = cpg_pkg::CPG_UNDEF;
      end else if (!sysregEnable) begin
         result = cpg_pkg::CPG_UNDEF;
      end else if (isAlias) begin
         if (!isWrite) begin
            result = cpg_pkg::CPG_UNDEF;
         end else if (nsEl1 && (irqRouteToHyp || fiqRouteToHyp
                                || trapCommon || hypTrapC12)) begin
            result = cpg_pkg::CPG_TRAP_HYP;
         end else if (monTrap && ((level == cpg_pkg::CPG_EL1 && secureState)
                                  || level == cpg_pkg::CPG_EL2)) begin
            result = cpg_pkg::CPG_TRAP_MON;
         end
      end else if (nsEl1 && irqRouteToHyp) begin
         result = cpg_pkg::CPG_VIRTUAL;
      end else if (nsEl1 && (trapAllGroup1 || hypTrapC12)) begin
         result = cpg_pkg::CPG_TRAP_HYP;
      end else if (monTrap && ((level == cpg_pkg::CPG_EL1 && secureState)
                               || level == cpg_pkg::CPG_EL2)) begin
         result = cpg_pkg::CPG_TRAP_MON;
      end else if (secureState && level != cpg_pkg::CPG_EL3) begin
         // secure copy only at the top level in secure state
         result = cpg_pkg::CPG_UNDEF;
      end
   end
endmodule : cpg_access_check

// ### src/cpg_sgi_encode.sv
`timescale 1ns/100ps
// unpacks an alias write into the generate packet fields
module cpg_sgi_encode (
   input  wire logic [63:0] wdata,
   input  wire logic        secureState,
   output logic       [7:0] affLvl3,
   output logic       [7:0] affLvl2,
   output logic       [7:0] affLvl1,
   output logic       [3:0] intNum,
   output logic             allButSelf,
   output logic      [15:0] targetMask,
   output logic             targetSecure
);
   always_comb begin
      allButSelf   = wdata[cpg_pkg::ROUTE_MODE_BIT];
      intNum       = wdata[cpg_pkg::INTNUM_LSB +: cpg_pkg::INTNUM_W];
      // routing to all others forces affinity and mask to zero
      affLvl3      = allButSelf ? 8'h00
                     : wdata[cpg_pkg::AFF_LVL3_LSB +: cpg_pkg::AFF_W];
      affLvl2      = allButSelf ? 8'h00
                     : wdata[cpg_pkg::AFF_LVL2_LSB +: cpg_pkg::AFF_W];
      affLvl1      = allButSelf ? 8'h00
                     : wdata[cpg_pkg::AFF_LVL1_LSB +: cpg_pkg::AFF_W];
      targetMask   = allButSelf ? 16'h0000
                     : wdata[cpg_pkg::TARGET_LSB +: cpg_pkg::TARGET_W];
      targetSecure = !secureState;
   end
endmodule : cpg_sgi_encode

// ### src/cpg_prio_sgi.sv
`timescale 1ns/100ps
//---------------------------------------------------------------------
// Operation
//---------------------------------------------------------------------
// Operation
// - all-zero active priority value means no interrupt is active
// - active priority registers reset to zero
// - instance 1 needs 6 priority bits, instances 2 and 3 need 7
// - secure copy at top secure level; non-secure copy at levels 1-3
// - non-secure level 1 goes virtual while irq route to hyp is set
// - sysreg enable low makes the access undefined
// - trap all group 1 or c12 trap sends level 1 access to hyp
// - irq to monitor traps secure level 1 and hyp accesses to monitor
// - alias register is 64-bit write only, targets other security state
// - affinity fields at 55:48, 39:32, 23:16; other bits zero
// - interrupt number sits at bits 27:24
// - routing mode 1 targets all but self, fields treated as zero
// - 16-bit target mask, bit n selects processor n
// - route, common or c12 trap sends level 1 alias writes to hyp
// - fiq and irq to monitor trap secure el1 and hyp alias writes
//---------------------------------------------------------------------
module cpg_prio_sgi #(
   parameter int PRIO_BITS = 5
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        accValid,
   input  wire logic        accWrite,
   input  wire logic        accAlias,
   input  wire logic  [1:0] accIndex,
   input  wire logic [63:0] accWdata,
   input  wire logic  [1:0] curLevel,
   input  wire logic        secureState,
   input  wire logic        sysregEnable,
   input  wire logic        irqRouteToHyp,
   input  wire logic        fiqRouteToHyp,
   input  wire logic        trapAllGroup1,
   input  wire logic        trapCommon,
   input  wire logic        hypTrapC12,
   input  wire logic        irqToMonitor,
   input  wire logic        fiqToMonitor,
   input  wire logic        monitorIs64,
   input  wire logic        pktAck,
   output logic             accReady,
   output logic             accDone,
   output logic       [2:0] accResult,
   output logic      [31:0] accRdata,
   output logic             pktValid,
   output logic       [7:0] pktAffLvl3,
   output logic       [7:0] pktAffLvl2,
   output logic       [7:0] pktAffLvl1,
   output logic       [3:0] pktIntNum,
   output logic             pktAllButSelf,
   output logic      [15:0] pktTargetMask,
   output logic             pktTargetSecure,
   output logic             activeNs,
   output logic             activeSec
);
   //------------------------------------------------------------------
   // state
   //------------------------------------------------------------------
   typedef struct packed {
      logic [3:0][31:0]  prioSec;
      logic [3:0][31:0]  prioNs;
      cpg_pkg::cpg_pkt_e pktState;
      logic              done;
      logic [2:0]        result;
      logic [31:0]       rdata;
      logic [7:0]        affLvl3;
      logic [7:0]        affLvl2;
      logic [7:0]        affLvl1;
      logic [3:0]        intNum;
      logic              allButSelf;
      logic [15:0]       mask;
      logic              tgtSecure;
      logic              actNs;
      logic              actSec;
   } cpg_state_s;

   cpg_state_s st_r;
   cpg_state_s st_nxt;

   logic [2:0]  chkResult;
   logic [7:0]  eAffLvl3;
   logic [7:0]  eAffLvl2;
   logic [7:0]  eAffLvl1;
   logic [3:0]  eInt;
   logic        eAll;
   logic [15:0] eMask;
   logic        eSec;
   logic        idxOk;
   logic        useSec;
   logic        take;

   function automatic logic prio_inst_ok(input logic [1:0] idx);
      case (idx)
         2'h0:    prio_inst_ok = 1'b1;
         2'h1:    prio_inst_ok = PRIO_BITS >= cpg_pkg::PRIO_BITS_AP1;
         default: prio_inst_ok = PRIO_BITS >= cpg_pkg::PRIO_BITS_AP23;
      endcase
   endfunction : prio_inst_ok

   function automatic logic any_active(input logic [3:0][31:0] regs);
      any_active = |regs;
   endfunction : any_active

   cpg_access_check u_check (
      .level         (curLevel),
      .secureState   (secureState),
      .isAlias       (accAlias),
      .isWrite       (accWrite),
      .sysregEnable  (sysregEnable),
      .irqRouteToHyp (irqRouteToHyp),
      .fiqRouteToHyp (fiqRouteToHyp),
      .trapAllGroup1 (trapAllGroup1),
      .trapCommon    (trapCommon),
      .hypTrapC12    (hypTrapC12),
      .irqToMonitor  (irqToMonitor),
      .fiqToMonitor  (fiqToMonitor),
      .monitorIs64   (monitorIs64),
      .result        (chkResult)
   );

   cpg_sgi_encode u_enc (
      .wdata        (accWdata),
      .secureState  (secureState),
      .affLvl3      (eAffLvl3),
      .affLvl2      (eAffLvl2),
      .affLvl1      (eAffLvl1),
      .intNum       (eInt),
      .allButSelf   (eAll),
      .targetMask   (eMask),
      .targetSecure (eSec)
   );

   //------------------------------------------------------------------
   // next state
   //------------------------------------------------------------------
   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      // an alias write waits while a packet is still outstanding, so
      // packets leave in program order without a queue
      take   = accValid
               && !(accAlias && st_r.pktState != cpg_pkg::CPG_PKT_IDLE);
      idxOk  = prio_inst_ok(accIndex);
      // secure copy only from secure state; level 3 non-secure sees ns copy
      useSec = secureState;

      unique case (st_r.pktState)
         cpg_pkg::CPG_PKT_IDLE: begin
         end
         cpg_pkg::CPG_PKT_SEND: begin
            // the distributor acknowledges every packet
            if (pktAck) begin
               st_nxt.pktState = cpg_pkg::CPG_PKT_IDLE;
            end
         end
         default: st_nxt.pktState = cpg_pkg::CPG_PKT_IDLE;
      endcase

      if (take) begin
         st_nxt.done   = 1'b1;
         st_nxt.rdata  = 32'h0000_0000;
         st_nxt.result = chkResult;
         if (!accAlias && chkResult == cpg_pkg::CPG_OK && !idxOk) begin
            st_nxt.result = cpg_pkg::CPG_UNDEF;
         end else if (accAlias && chkResult == cpg_pkg::CPG_OK) begin
            st_nxt.pktState  = cpg_pkg::CPG_PKT_SEND;
            st_nxt.affLvl3   = eAffLvl3;
            st_nxt.affLvl2   = eAffLvl2;
            st_nxt.affLvl1   = eAffLvl1;
            st_nxt.intNum    = eInt;
            st_nxt.allButSelf = eAll;
            st_nxt.mask      = eMask;
            st_nxt.tgtSecure = eSec;
         end else if (!accAlias && chkResult == cpg_pkg::CPG_OK) begin
            if (accWrite) begin
               if (useSec) begin
                  st_nxt.prioSec[accIndex] = accWdata[31:0];
               end else begin
                  st_nxt.prioNs[accIndex]  = accWdata[31:0];
               end
            end else begin
               st_nxt.rdata = useSec ? st_r.prioSec[accIndex]
                                     : st_r.prioNs[accIndex];
            end
         end
      end

      st_nxt.actNs  = any_active(st_nxt.prioNs);
      st_nxt.actSec = any_active(st_nxt.prioSec);

      if (!rst_n) begin
         st_nxt          = '0;
         st_nxt.pktState = cpg_pkg::CPG_PKT_IDLE;
         for (int i = 0; i < cpg_pkg::NUM_PRIO_REGS; i++) begin
            st_nxt.prioSec[i] = cpg_pkg::PRIO_RESET;
            st_nxt.prioNs[i]  = cpg_pkg::PRIO_RESET;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      st_r <= st_nxt;
   end

   //------------------------------------------------------------------
   // outputs
   //------------------------------------------------------------------
   always_comb begin
      accReady        = 1'b1;
      accDone         = st_r.done;
      accResult       = st_r.result;
      accRdata        = st_r.rdata;
      pktValid        = st_r.pktState == cpg_pkg::CPG_PKT_SEND;
      pktAffLvl3      = st_r.affLvl3;
      pktAffLvl2      = st_r.affLvl2;
      pktAffLvl1      = st_r.affLvl1;
      pktIntNum       = st_r.intNum;
      pktAllButSelf   = st_r.allButSelf;
      pktTargetMask   = st_r.mask;
      pktTargetSecure = st_r.tgtSecure;
      activeNs        = st_r.actNs;
      activeSec       = st_r.actSec;
      // ready drops only for an alias access while a packet is busy, holding it off
      if (accAlias && st_r.pktState != cpg_pkg::CPG_PKT_IDLE) begin
         accReady = 1'b0;
      end
   end
endmodule : cpg_prio_sgi

// ### verification/cpg_prio_sgi_asserts.sv
`timescale 1ns/100ps
module cpg_prio_sgi_asserts #(
   parameter int PRIO_BITS = 5
) (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        accValid,
   input wire logic        accReady,
   input wire logic        accAlias,
   input wire logic        accWrite,
   input wire logic [63:0] accWdata,
   input wire logic        secureState,
   input wire logic        pktAck,
   input wire logic        accDone,
   input wire logic  [2:0] accResult,
   input wire logic        pktValid,
   input wire logic  [3:0] pktIntNum,
   input wire logic        pktAllButSelf,
   input wire logic [15:0] pktTargetMask,
   input wire logic        pktTargetSecure
);
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   wire take    = accValid && accReady;
   wire aliasWr = take && accAlias && accWrite;

   a_done_on_take: assert property (take |=> accDone)
      else $error("no completion after an accepted access");
   a_no_stray_done: assert property (!take |=> !accDone)
      else $error("completion without an access");
   a_pkt_per_write: assert property (
      aliasWr |=> pktValid == (accResult == 3'h0))
      else $error("packet does not match alias write outcome");
   a_pkt_holds: assert property (
      pktValid && !pktAck |=> pktValid && $stable(pktTargetMask)
         && $stable(pktIntNum))
      else $error("packet changed before acknowledge");
   a_pkt_retires: assert property (pktValid && pktAck |=> !pktValid)
      else $error("packet still offered after acknowledge");
   a_busy_refuse: assert property (pktValid && accAlias |-> !accReady)
      else $error("alias write accepted while packet pending");
   a_all_mask_zero: assert property (
      pktValid && pktAllButSelf |-> pktTargetMask == 16'h0000)
      else $error("mask kept in all-but-self mode");
   a_fields_copy: assert property (
      aliasWr ##1 pktValid |-> pktIntNum == $past(accWdata[27:24])
         && pktTargetSecure != $past(secureState))
      else $error("packet number or security state wrong");
   a_mask_copy: assert property (
      aliasWr && !accWdata[40] ##1 pktValid
         |-> pktTargetMask == $past(accWdata[15:0]))
      else $error("target mask not copied");
   a_reset_clear: assert property ($rose(rst_n) |-> !pktValid && !accDone)
      else $error("outputs not cleared by reset");
endmodule : cpg_prio_sgi_asserts

bind cpg_prio_sgi cpg_prio_sgi_asserts #(.PRIO_BITS(PRIO_BITS)) u_chk (
   .ref_clk, .rst_n, .accValid, .accReady, .accAlias, .accWrite,
   .accWdata, .secureState, .pktAck, .accDone, .accResult, .pktValid,
   .pktIntNum, .pktAllButSelf, .pktTargetMask, .pktTargetSecure);

// ### verification/cpg_dist_model.sv
`timescale 1ns/100ps
module cpg_dist_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       pktValid,
   input  wire logic [1:0] ackDelay,
   output logic            pktAck,
   output int              pktCount
);
   logic [1:0] waitCnt;
   // every packet is taken whatever its targets
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         pktAck <= 1'b0;
         waitCnt <= 2'h0;
         pktCount <= 0;
      end else if (pktAck) begin
         pktAck <= 1'b0;
         waitCnt <= 2'h0;
         pktCount <= pktCount + 1;
      end else if (pktValid) begin
         if (waitCnt == ackDelay)
            pktAck <= 1'b1;
         else
            waitCnt <= waitCnt + 2'h1;
      end
   end
endmodule : cpg_dist_model

// ### verification/cpg_prio_sgi_tb.sv
`timescale 1ns/100ps
module cpg_prio_sgi_tb;
   logic        ref_clk, rst_n, accValid, accWrite, accAlias, secureState;
   logic        sysregEnable, irqRouteToHyp, fiqRouteToHyp, trapAllGroup1;
   logic        trapCommon, hypTrapC12, irqToMonitor, fiqToMonitor;
   logic        monitorIs64, accReady, accDone, pktValid, pktAck;
   logic        pktAllButSelf, pktTargetSecure, activeNs, activeSec;
   logic [1:0]  accIndex, curLevel, ackDelay;
   logic [2:0]  accResult, res5;
   logic [3:0]  pktIntNum;
   logic [7:0]  pktAffLvl3, pktAffLvl2, pktAffLvl1;
   logic [15:0] pktTargetMask;
   logic [31:0] accRdata, rdata5, seed, r;
   logic [31:0] prio [2][4];
   logic [63:0] accWdata;
   int          n_mismatch, cmp_count, pktCount, expPkts;

   cpg_prio_sgi #(.PRIO_BITS(7)) dut (
      .ref_clk, .rst_n, .accValid, .accWrite, .accAlias, .accIndex,
      .accWdata, .curLevel, .secureState, .sysregEnable, .irqRouteToHyp,
      .fiqRouteToHyp, .trapAllGroup1, .trapCommon, .hypTrapC12,
      .irqToMonitor, .fiqToMonitor, .monitorIs64, .pktAck, .accReady,
      .accDone, .accResult, .accRdata, .pktValid, .pktAffLvl3, .pktAffLvl2,
      .pktAffLvl1, .pktIntNum, .pktAllButSelf, .pktTargetMask,
      .pktTargetSecure, .activeNs, .activeSec);
   // default priority width: instances above 0 are not implemented
   cpg_prio_sgi #(.PRIO_BITS(cpg_pkg::PRIO_BITS_DEF)) dut5 (
      .ref_clk, .rst_n, .accValid, .accWrite, .accAlias, .accIndex,
      .accWdata, .curLevel, .secureState, .sysregEnable, .irqRouteToHyp,
      .fiqRouteToHyp, .trapAllGroup1, .trapCommon, .hypTrapC12,
      .irqToMonitor, .fiqToMonitor, .monitorIs64, .pktAck,
      .accReady(), .accDone(), .accResult(res5), .accRdata(rdata5),
      .pktValid(), .pktAffLvl3(), .pktAffLvl2(), .pktAffLvl1(),
      .pktIntNum(), .pktAllButSelf(), .pktTargetMask(),
      .pktTargetSecure(), .activeNs(), .activeSec());
   cpg_dist_model u_dist (
      .ref_clk, .rst_n, .pktValid, .ackDelay, .pktAck, .pktCount);

   always #20 ref_clk = ~ref_clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
      end
   endtask : check

   function automatic logic [2:0] expResult();
      logic ns1;
      logic mon;
      ns1 = !secureState && curLevel == 2'h1;
      mon = monitorIs64 && irqToMonitor && (fiqToMonitor || !accAlias)
         && (curLevel == 2'h2 || (secureState && curLevel == 2'h1));
      if (curLevel == 2'h0 || !sysregEnable || (accAlias && !accWrite))
         return 3'h1;
      if (!accAlias && ns1 && irqRouteToHyp)
         return 3'h4;
      if (ns1 && (accAlias ? (irqRouteToHyp || fiqRouteToHyp || trapCommon
            || hypTrapC12) : (trapAllGroup1 || hypTrapC12)))
         return 3'h2;
      if (mon)
         return 3'h3;
      if (!accAlias && secureState && curLevel != 2'h3)
         return 3'h1;
      return 3'h0;
   endfunction : expResult

   function automatic logic anyAct(input logic s);
      return (prio[s][0] | prio[s][1] | prio[s][2] | prio[s][3]) != 32'h0;
   endfunction : anyAct

   // c packs level, security, config bits and the operation together
   task automatic access(input logic [31:0] c, input logic [63:0] wd);
      logic [2:0] e;
      logic [2:0] e5;
      logic       s;
      logic       ns1;
      int         n;
      @(posedge ref_clk);
      ns1 = c[1:0] == 2'h1 && !c[2];
      curLevel <= c[1:0];
      secureState <= c[2] && c[0];
      sysregEnable <= c[5:3] != 3'h0;
      {irqRouteToHyp, fiqRouteToHyp, trapAllGroup1} <= {&c[7:6], &c[9:8],
         &c[11:10]};
      {trapCommon, hypTrapC12, monitorIs64} <= {&c[13:12], &c[15:14], c[16]};
      // non-secure level 1 monitor traps are left out of the model
      irqToMonitor <= c[16] && c[17] && !ns1;
      fiqToMonitor <= c[16] && c[18] && !ns1;
      ackDelay <= c[20:19];
      {accValid, accWrite, accAlias} <= {1'b1, c[21], c[22]};
      {accIndex, accWdata} <= {c[25:24], wd};
      n = 0;
      @(negedge ref_clk);
      check({activeSec, activeNs}, {anyAct(1'b1), anyAct(1'b0)});
      while (!accReady && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      check(accReady, 1'b1);
      e = expResult();
      s = secureState;
      // five priority bits implement instance 0 only
      e5 = (e == 3'h0 && !accAlias && accIndex != 2'h0) ? 3'h1 : e;
      @(posedge ref_clk);
      accValid <= 1'b0;
      @(negedge ref_clk);
      check({accDone, accResult}, {1'b1, e});
      check(accRdata, (e == 3'h0 && !accAlias && !accWrite) ?
         prio[s][accIndex] : 32'h0);
      check(res5, e5);
      check(rdata5, (e5 == 3'h0 && !accAlias && !accWrite) ?
         prio[s][accIndex] : 32'h0);
      if (e == 3'h0 && !accAlias && accWrite)
         prio[s][accIndex] = wd[31:0];
      if (e == 3'h0 && accAlias) begin
         expPkts++;
         check({pktValid, pktTargetSecure, pktIntNum},
            {1'b1, !s, wd[27:24]});
         check({pktAllButSelf, pktTargetMask,
            pktAffLvl3, pktAffLvl2, pktAffLvl1}, wd[40] ? {1'b1, 40'h0}
            : {1'b0, wd[15:0], wd[55:48], wd[39:32], wd[23:16]});
      end
   endtask : access

   // secure copies are always visited before the non-secure ones
   task automatic sweep(input logic wr, input logic rd);
      for (int s = 1; s >= 0; s--) begin
         for (int i = 0; i < 4; i++) begin
            access(32'h0000_003B | (wr << 21) | (s << 2) | (i << 24),
               rd ? {32'h0, rnd()} : 64'h0);
         end
      end
   endtask : sweep

   task automatic doReset();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      prio = '{default: 32'h0};
      expPkts = 0;
   endtask : doReset

   task automatic results();
      $display("counts: %0d compared, %0d mismatched", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      seed = 32'h642f_e349;
      {accValid, accWrite, accAlias, accIndex, accWdata, curLevel} = '0;
      {secureState, sysregEnable, irqRouteToHyp, fiqRouteToHyp} = '0;
      {trapAllGroup1, trapCommon, hypTrapC12, irqToMonitor} = '0;
      {fiqToMonitor, monitorIs64, ackDelay} = '0;
      n_mismatch = 0;
      cmp_count = 0;
      doReset();
      sweep(1'b0, 1'b0);
      $display("test reset: done");
      sweep(1'b1, 1'b1);
      sweep(1'b0, 1'b0);
      $display("test priority: done");
      repeat (150) begin
         r = rnd();
         // priority writes only put back the held value or zero
         access(r, {rnd(), r[22] ? rnd()
            : (r[26] ? prio[r[2] && r[0]][r[25:24]] : 32'h0)});
      end
      repeat (8) @(posedge ref_clk);
      check(pktCount, expPkts);
      $display("test random: done");
      sweep(1'b1, 1'b0);
      sweep(1'b0, 1'b0);
      $display("test clear: done");
      doReset();
      sweep(1'b0, 1'b0);
      $display("test second reset: done");
      results();
   end

   initial begin
      #800000;
      n_mismatch++;
      results();
   end
endmodule : cpg_prio_sgi_tb
